// *** core/clhp_pkg.sv ***
/*
  Shared constants and types of the character panel host port and font memory.
  Assumes a single 50 MHz clock and a synchronous active-high reset.
*/
// Behaviour
// - link kind from select pins, width from function set bit 4
// - two 8-bit registers: instruction and data staging
// - data read prefetches next RAM byte
// - data write copies byte into addressed RAM
// - instruction register is write only
// - select and direction decode four operations
// - busy blocks instructions until operation ends
// - busy readback only on parallel links
// - display RAM holds 80 character codes
// - two-line mode splits line addresses apart
// - display shift remaps positions, RAM untouched
// - each RAM access steps counter by one
// - address instruction loads address counter
// - 16 or 8 commons, 40 segments
// - pixels shifted into chain, then latched
// - fixed ROM: 256 glyphs of 5x8
// - user font RAM holds 8 glyphs
// - code bits 0-2 pick user glyph
// - low address bits pick row; row 7 ORs cursor
// - pixels in bits 0-4, bit 4 leftmost
// - user glyphs when code high nibble zero and font_bank_select low
// - direction bit picks up or down step
// - 7-bit display, 6-bit font addresses
package clhp_pkg;

  // ---------------------------------------------------------------
  // link and map
  // ---------------------------------------------------------------
  localparam logic [1:0] IFACE_PAR      = 2'b00;
  localparam int         DISP_DEPTH     = 80;
  localparam logic [6:0] DISP_LAST_1L   = 7'h4F;
  localparam logic [6:0] LINE1_LAST     = 7'h27;
  localparam logic [6:0] LINE2_FIRST    = 7'h40;
  localparam logic [6:0] LINE2_LAST     = 7'h67;
  localparam logic [6:0] LINE2_TO_IDX   = 7'h18;
  localparam logic [6:0] LINE_LEN       = 7'd40;
  localparam logic [6:0] FULL_LEN       = 7'd80;
  localparam logic [7:0] SPACE_CODE     = 8'h20;
  localparam logic [2:0] CURSOR_ROW     = 3'h7;
  localparam logic [2:0] LAST_CHAR      = 3'h7;
  localparam logic [2:0] LAST_BIT       = 3'h4;

  // ---------------------------------------------------------------
  // reset values
  // ---------------------------------------------------------------
  localparam logic RST_WIDTH8 = 1'b1;
  localparam logic RST_INC    = 1'b1;
  localparam logic RST_TWO    = 1'b1;

  // ---------------------------------------------------------------
  // timing
  // ---------------------------------------------------------------
  localparam int CLK_MHZ      = 50;
  localparam int EXEC_NS      = 18500;
  localparam int LONG_NS      = 760000;
  localparam int BLINK_US     = 185000;
  localparam int EXEC_CYC     = (EXEC_NS * CLK_MHZ + 999) / 1000;
  localparam int LONG_CYC_DEF = (LONG_NS * CLK_MHZ + 999) / 1000;
  localparam int BLINK_CYC_DEF = BLINK_US * CLK_MHZ;

  typedef enum logic [1:0] {CLHP_IDLE, CLHP_BUSY, CLHP_CLEAR} clhp_op_t;

  typedef struct packed {
    clhp_op_t    op;
    logic [23:0] cnt;
    logic [23:0] blink_cnt;
    logic        blink_ph;
    logic [6:0]  ac;
    logic        font_sel;
    logic        inc;
    logic        shift_en;
    logic        disp_on;
    logic        cur_on;
    logic        blink_on;
    logic        width8;
    logic        two_line;
    logic [6:0]  disp_shift;
    logic [7:0]  instruction_holding;
    logic [7:0]  data_staging;
    logic        nib_second;
    logic [3:0]  nib_buf;
    logic [7:0]  dout;
    logic        fetch;
    logic [6:0]  clr_idx;
    logic [3:0]  com;
    logic [2:0]  chr;
    logic [2:0]  bitn;
    logic [39:0] chain;
    logic [39:0] seg;
    logic [15:0] com_out;
  } clhp_state_t;

endpackage : clhp_pkg

// *** core/clhp_font_if.sv ***
/*
  Carrier between the port logic and the font memory.
  Assumes both ends run on sys_clk.
*/
interface clhp_font_if;
  logic       wr_en;
  logic [5:0] wr_addr;
  logic [4:0] wr_data;
  logic [5:0] rd_addr;
  logic [4:0] rd_data;
  logic [7:0] code;
  logic [2:0] row;
  logic       bank;
  logic [4:0] pixels;

  modport port (output wr_en, wr_addr, wr_data, rd_addr, code, row, bank, input rd_data, pixels);
  modport mem  (input wr_en, wr_addr, wr_data, rd_addr, code, row, bank, output rd_data, pixels);
endinterface : clhp_font_if

// *** core/clhp_font.sv ***
/*
  Font memory: user glyph RAM and fixed glyph ROM with row lookup.
  Assumes writes come one per clock from the port logic.
*/
module clhp_font
  import clhp_pkg::*;
(
  input  wire logic sys_clk,
  clhp_font_if.mem  fif
);

  logic [4:0] user_ram [0:63];
  logic [5:0] glyph_addr;

  // ---------------------------------------------------------------
  // fixed glyphs
  // ---------------------------------------------------------------
  // stand-in pattern; bottom row kept dark so the cursor shows cleanly
  function automatic logic [4:0] rom_row(input logic [7:0] code, input logic [2:0] row);
    rom_row = (row == CURSOR_ROW) ? 5'h00 : (code[4:0] ^ {row, row[1:0]});
  endfunction : rom_row

  always_ff @(posedge sys_clk)
  begin
    if (fif.wr_en)
    begin
      user_ram[fif.wr_addr] <= fif.wr_data;
    end
  end

  assign glyph_addr  = {fif.code[2:0], fif.row};
  assign fif.rd_data = user_ram[fif.rd_addr];
  // code bit 3 is not decoded, so 00H and 08H alias
  assign fif.pixels  = (fif.code[7:4] == 4'h0 && !fif.bank) ? user_ram[glyph_addr]
                                                            : rom_row(fif.code, fif.row);

endmodule : clhp_font

// *** core/clhp_top.sv ***
/*
  Host port, address counter, display RAM and panel scan of the character panel controller.
  Assumes host pins are synchronous to sys_clk and bus_strobe pulses one cycle per transfer.
*/
module clhp_top
  import clhp_pkg::*;
#(
  parameter int LONG_CYC  = LONG_CYC_DEF,
  parameter int BLINK_CYC = BLINK_CYC_DEF
)
(
  input  wire logic        sys_clk,
  input  wire logic        rst,
  input  wire logic        iface_select_hi,
  input  wire logic        iface_select_lo,
  input  wire logic        font_bank_select,
  input  wire logic        register_select,
  input  wire logic        bus_dir_read,
  input  wire logic        bus_strobe,
  input  wire logic [7:0]  bus_data_in,
  output logic      [7:0]  bus_data_out,
  output logic             bus_data_oe,
  output logic      [15:0] com_out,
  output logic      [39:0] seg_out
);

  clhp_state_t s_reg;
  clhp_state_t s_next;
  clhp_font_if fif ();

  logic [7:0] disp_ram [0:DISP_DEPTH-1];
  logic       parallel_sel;
  logic       take;
  logic       byte_done;
  logic [7:0] host_byte;
  logic       dram_we;
  logic [6:0] dram_waddr;
  logic [7:0] dram_wdata;
  logic [6:0] cell_addr;
  logic [6:0] cell_pos;
  logic [7:0] cell_code;
  logic [4:0] cell_pix;
  logic       cur_hit;
  logic [7:0] status_byte;
  logic [6:0] shift_lim;

  // ---------------------------------------------------------------
  // address helpers
  // ---------------------------------------------------------------
  // second line lives at 40H, so its index into the array is folded down
  function automatic logic [6:0] disp_idx(input logic [6:0] a, input logic two);
    disp_idx = (two && a[6]) ? (a - LINE2_TO_IDX) : a;
  endfunction : disp_idx

  function automatic logic [6:0] step_ac(input logic [6:0] a, input logic up, input logic font,
                                         input logic two);
    logic [6:0] r;
    r = up ? a + 7'd1 : a - 7'd1;
    if (font)
    begin
      r = {1'b0, r[5:0]};
    end
    else if (two)
    begin
      if (up && a == LINE1_LAST)
      begin
        r = LINE2_FIRST;
      end
      else if (up && a == LINE2_LAST)
      begin
        r = 7'h00;
      end
      else if (!up && a == LINE2_FIRST)
      begin
        r = LINE1_LAST;
      end
      else if (!up && a == 7'h00)
      begin
        r = LINE2_LAST;
      end
    end
    else if (up && a == DISP_LAST_1L)
    begin
      r = 7'h00;
    end
    else if (!up && a == 7'h00)
    begin
      r = DISP_LAST_1L;
    end
    step_ac = r;
  endfunction : step_ac

  function automatic logic [6:0] move_shift(input logic [6:0] sh, input logic left, input logic [6:0] lim);
    if (left)
    begin
      move_shift = (sh == lim - 7'd1) ? 7'd0 : sh + 7'd1;
    end
    else
    begin
      move_shift = (sh == 7'd0) ? lim - 7'd1 : sh - 7'd1;
    end
  endfunction : move_shift

  // ---------------------------------------------------------------
  // host side decode
  // ---------------------------------------------------------------
  assign parallel_sel = ({iface_select_hi, iface_select_lo} == IFACE_PAR);
  assign take         = bus_strobe && parallel_sel;
  assign byte_done    = s_reg.width8 || s_reg.nib_second;
  assign host_byte    = s_reg.width8 ? bus_data_in : {s_reg.nib_buf, bus_data_in[7:4]};
  assign status_byte  = {s_reg.op != CLHP_IDLE, s_reg.ac};
  assign shift_lim    = s_reg.two_line ? LINE_LEN : FULL_LEN;
  assign bus_data_out = s_reg.dout;
  assign bus_data_oe  = parallel_sel && bus_dir_read;
  assign com_out      = s_reg.com_out;
  assign seg_out      = s_reg.seg;

  // ---------------------------------------------------------------
  // scan lookup
  // ---------------------------------------------------------------
  always_comb
  begin
    cell_pos = 7'({4'h0, s_reg.chr} + s_reg.disp_shift);
    if (cell_pos >= shift_lim)
    begin
      cell_pos = cell_pos - shift_lim;
    end
    cell_addr = (s_reg.two_line && s_reg.com[3]) ? (LINE2_FIRST + cell_pos) : cell_pos;
  end

  assign cell_code   = disp_ram[disp_idx(cell_addr, s_reg.two_line)];
  assign fif.code    = cell_code;
  assign fif.row     = s_reg.com[2:0];
  assign fif.bank    = font_bank_select;
  assign fif.rd_addr = s_reg.ac[5:0];
  assign cur_hit     = s_reg.cur_on && !s_reg.font_sel && cell_addr == s_reg.ac;
  // cursor is OR-ed onto the bottom row; with the cursor on, blink lights the whole cell on one phase
  assign cell_pix    = fif.pixels
                     | ((cur_hit && s_reg.com[2:0] == CURSOR_ROW) ? 5'h1F : 5'h00)
                     | ((cur_hit && s_reg.blink_on && s_reg.blink_ph) ? 5'h1F : 5'h00);

  // ---------------------------------------------------------------
  // next state
  // ---------------------------------------------------------------
  always_comb
  begin
    s_next      = s_reg;
    dram_we     = 1'b0;
    dram_waddr  = disp_idx(s_reg.ac, s_reg.two_line);
    dram_wdata  = host_byte;
    fif.wr_en   = 1'b0;
    fif.wr_addr = s_reg.ac[5:0];
    fif.wr_data = host_byte[4:0];

    if (s_reg.blink_cnt == 24'(BLINK_CYC - 1))
    begin
      s_next.blink_cnt = 24'h000000;
      s_next.blink_ph  = !s_reg.blink_ph;
    end
    else
    begin
      s_next.blink_cnt = s_reg.blink_cnt + 24'h000001;
    end

    if (take)
    begin
      if (!s_reg.width8 && !s_reg.nib_second)
      begin
        s_next.nib_buf = bus_data_in[7:4];
      end
      s_next.nib_second = !s_reg.width8 && !s_reg.nib_second;
      if (bus_dir_read)
      begin
        // status reads are honoured even while busy, so the host can poll
        if (!register_select)
        begin
          s_next.dout = s_reg.width8      ? status_byte
                      : s_reg.nib_second  ? {status_byte[3:0], 4'h0}
                                          : {status_byte[7:4], 4'h0};
        end
        else
        begin
          s_next.dout = s_reg.width8      ? s_reg.data_staging
                      : s_reg.nib_second  ? {s_reg.data_staging[3:0], 4'h0}
                                          : {s_reg.data_staging[7:4], 4'h0};
        end
      end
    end

    unique case (s_reg.op)
      CLHP_IDLE:
      begin
        if (take && byte_done && !bus_dir_read && !register_select)
        begin
          s_next.instruction_holding = host_byte;
          s_next.op  = CLHP_BUSY;
          s_next.cnt = 24'(EXEC_CYC);
          casez (host_byte)
            8'b1???????:
            begin
              s_next.ac       = host_byte[6:0];
              s_next.font_sel = 1'b0;
              s_next.fetch    = 1'b1;
            end
            8'b01??????:
            begin
              s_next.ac       = {1'b0, host_byte[5:0]};
              s_next.font_sel = 1'b1;
              s_next.fetch    = 1'b1;
            end
            8'b001?????:
            begin
              s_next.width8   = host_byte[4];
              s_next.two_line = host_byte[3];
              s_next.disp_shift = 7'd0;
            end
            8'b0001????:
            begin
              if (host_byte[3])
              begin
                s_next.disp_shift = move_shift(s_reg.disp_shift, !host_byte[2], shift_lim);
              end
              else
              begin
                s_next.ac = step_ac(s_reg.ac, host_byte[2], s_reg.font_sel, s_reg.two_line);
              end
            end
            8'b00001???:
            begin
              s_next.disp_on  = host_byte[2];
              s_next.cur_on   = host_byte[1];
              s_next.blink_on = host_byte[0];
            end
            8'b000001??:
            begin
              s_next.inc      = host_byte[1];
              s_next.shift_en = host_byte[0];
            end
            8'b0000001?:
            begin
              s_next.ac         = 7'h00;
              s_next.font_sel   = 1'b0;
              s_next.disp_shift = 7'd0;
              s_next.cnt        = 24'(LONG_CYC);
            end
            8'b00000001:
            begin
              s_next.op         = CLHP_CLEAR;
              s_next.clr_idx    = 7'd0;
              s_next.ac         = 7'h00;
              s_next.inc        = 1'b1;
              s_next.font_sel   = 1'b0;
              s_next.disp_shift = 7'd0;
            end
            default:
            begin
              s_next.cnt = 24'(EXEC_CYC);
            end
          endcase
        end
        else if (take && byte_done && register_select)
        begin
          s_next.op  = CLHP_BUSY;
          s_next.cnt = 24'(EXEC_CYC);
          s_next.ac  = step_ac(s_reg.ac, s_reg.inc, s_reg.font_sel, s_reg.two_line);
          if (bus_dir_read)
          begin
            s_next.fetch = 1'b1;
          end
          else
          begin
            s_next.data_staging = host_byte;
            dram_we   = !s_reg.font_sel && dram_waddr < 7'(DISP_DEPTH);
            fif.wr_en = s_reg.font_sel;
            if (s_reg.shift_en && !s_reg.font_sel)
            begin
              s_next.disp_shift = move_shift(s_reg.disp_shift, s_reg.inc, shift_lim);
            end
          end
        end
      end
      CLHP_BUSY:
      begin
        // instructions and data writes arriving here are dropped
        s_next.cnt = s_reg.cnt - 24'h000001;
        if (s_reg.cnt <= 24'h000001)
        begin
          s_next.op    = CLHP_IDLE;
          s_next.fetch = 1'b0;
          if (s_reg.fetch)
          begin
            s_next.data_staging = s_reg.font_sel ? {3'h0, fif.rd_data}
                                                 : disp_ram[disp_idx(s_reg.ac, s_reg.two_line)];
          end
        end
      end
      CLHP_CLEAR:
      begin
        dram_we    = 1'b1;
        dram_waddr = s_reg.clr_idx;
        dram_wdata = SPACE_CODE;
        s_next.clr_idx = s_reg.clr_idx + 7'd1;
        if (s_reg.clr_idx == 7'(DISP_DEPTH - 1))
        begin
          s_next.op  = CLHP_BUSY;
          s_next.cnt = 24'(LONG_CYC);
        end
      end
    endcase

    // panel scan: one pixel per clock into the chain, latch after 40
    s_next.chain = {s_reg.chain[38:0], cell_pix[3'd4 - s_reg.bitn]};
    if (s_reg.bitn == LAST_BIT)
    begin
      s_next.bitn = 3'd0;
      s_next.chr  = s_reg.chr + 3'd1;
      if (s_reg.chr == LAST_CHAR)
      begin
        s_next.seg     = s_reg.disp_on ? s_next.chain : 40'h0;
        s_next.com_out = 16'h0001 << s_reg.com;
        s_next.com     = (s_reg.com == (s_reg.two_line ? 4'hF : 4'h7)) ? 4'h0 : s_reg.com + 4'h1;
      end
    end
    else
    begin
      s_next.bitn = s_reg.bitn + 3'd1;
    end
  end

  // ---------------------------------------------------------------
  // registers
  // ---------------------------------------------------------------
  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      s_reg          <= '0;
      s_reg.op       <= CLHP_IDLE;
      s_reg.inc      <= RST_INC;
      s_reg.width8   <= RST_WIDTH8;
      s_reg.two_line <= RST_TWO;
    end
    else
    begin
      s_reg <= s_next;
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (dram_we)
    begin
      disp_ram[dram_waddr] <= dram_wdata;
    end
  end

  clhp_font u_font (
    .sys_clk (sys_clk),
    .fif     (fif.mem)
  );

endmodule : clhp_top

// *** tb/clhp_top_asserts.sv ***
/*
  Port checker of clhp_top, bound to every instance.
  Assumes one clock domain with rst as its synchronous reset.
*/
module clhp_top_asserts
  import clhp_pkg::*;
#(
  parameter int LONG_CYC  = LONG_CYC_DEF,
  parameter int BLINK_CYC = BLINK_CYC_DEF
)
(
  input wire logic        sys_clk,
  input wire logic        rst,
  input wire logic        iface_select_hi,
  input wire logic        iface_select_lo,
  input wire logic        font_bank_select,
  input wire logic        register_select,
  input wire logic        bus_dir_read,
  input wire logic        bus_strobe,
  input wire logic [7:0]  bus_data_in,
  input wire logic [7:0]  bus_data_out,
  input wire logic        bus_data_oe,
  input wire logic [15:0] com_out,
  input wire logic [39:0] seg_out
);
  timeunit 1ns;
  timeprecision 1ps;
  logic        par;
  logic        rd_stb;
  logic [15:0] com_prev_reg;
  logic [5:0]  line_cnt_reg;
  logic        cmd_seen_reg;

  assign par    = !iface_select_hi && !iface_select_lo;
  assign rd_stb = bus_strobe && par && bus_dir_read;

  // saturates so a stuck line cannot wrap into a false match
  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      com_prev_reg <= 16'h0000;
      line_cnt_reg <= 6'h00;
      cmd_seen_reg <= 1'h0;
    end
    else
    begin
      com_prev_reg <= com_out;
      line_cnt_reg <= (com_out != com_prev_reg) ? 6'h00 : ((line_cnt_reg == 6'h3F) ? 6'h3F : line_cnt_reg + 6'h01);
      cmd_seen_reg <= cmd_seen_reg | (bus_strobe && par && !register_select && !bus_dir_read);
    end
  end

  default clocking @(posedge sys_clk); endclocking
  default disable iff (rst);

  a_oe_read_drive: assert property (par && bus_dir_read |-> bus_data_oe)
    else $error("read bus not driven");
  a_oe_serial_quiet: assert property (!par || !bus_dir_read |-> !bus_data_oe)
    else $error("bus driven outside parallel read");
  a_dout_hold: assert property (!rd_stb |=> $stable(bus_data_out))
    else $error("read data moved without read");
  a_write_busy: assert property ((bus_strobe && par && register_select && !bus_dir_read) ##[2:50]
    (rd_stb && !register_select) |=> bus_data_out[7])
    else $error("no busy after data write");
  a_com_onehot: assert property ($onehot0(com_out))
    else $error("several commons active");
  a_seg_with_com: assert property ($stable(com_out) |-> $stable(seg_out))
    else $error("segments moved inside a line");
  a_line_length: assert property ((com_out != com_prev_reg) && com_prev_reg != 16'h0000 && com_out != 16'h0000
    |-> line_cnt_reg == 6'h27)
    else $error("scan line not 40 cycles");
  a_dark_until_cmd: assert property (!cmd_seen_reg |-> seg_out == 40'h0)
    else $error("segments lit before display on");
endmodule : clhp_top_asserts

bind clhp_top clhp_top_asserts #(.LONG_CYC(LONG_CYC), .BLINK_CYC(BLINK_CYC)) u_asserts (
  .sys_clk(sys_clk), .rst(rst), .iface_select_hi(iface_select_hi), .iface_select_lo(iface_select_lo),
  .font_bank_select(font_bank_select), .register_select(register_select), .bus_dir_read(bus_dir_read),
  .bus_strobe(bus_strobe), .bus_data_in(bus_data_in), .bus_data_out(bus_data_out),
  .bus_data_oe(bus_data_oe), .com_out(com_out), .seg_out(seg_out)
);

// *** tb/clhp_host.sv ***
/*
  Host processor model: one-cycle strobe transfers and busy polling.
  Assumes narrow is set by the bench while the port runs 4-bit.
*/
module clhp_host
(
  input  wire logic       sys_clk,
  input  wire logic [7:0] bus_data_out,
  output logic            register_select,
  output logic            bus_dir_read,
  output logic            bus_strobe,
  output logic      [7:0] bus_data_in
);
  timeunit 1ns;
  timeprecision 1ps;
  logic narrow = 1'h0;

  initial
  begin
    register_select = 1'h0;
    bus_dir_read    = 1'h0;
    bus_strobe      = 1'h0;
    bus_data_in     = 8'h00;
  end

  task automatic xfer(input logic rs, input logic rd, input logic [7:0] wdata, output logic [7:0] rdata);
    @(posedge sys_clk);
    register_select <= rs;
    bus_dir_read    <= rd;
    bus_data_in     <= wdata;
    bus_strobe      <= 1'h1;
    @(posedge sys_clk);
    bus_strobe      <= 1'h0;
    // released bus must not keep showing the byte
    bus_data_in     <= ~wdata;
    @(posedge sys_clk);
    rdata = bus_data_out;
  endtask : xfer

  task automatic wait_ready;
    logic [7:0] s;
    logic [7:0] s2;
    int         n;
    n = 0;
    do
    begin
      xfer(1'h0, 1'h1, 8'h00, s);
      if (narrow)
      begin
        xfer(1'h0, 1'h1, 8'h00, s2);
      end
      n++;
    end
    while (s[7] !== 1'h0 && n < 2000);
  endtask : wait_ready
endmodule : clhp_host

// *** tb/clhp_bench.sv ***
/*
  Self-checking bench of clhp_top.
  Assumes clhp_host drives the host pins and the checker is bound.
*/
module clhp_bench
  import clhp_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int LIMIT = 95000;
  logic        sys_clk = 1'h0;
  logic        rst = 1'h1;
  logic        iface_select_hi = 1'h0;
  logic        iface_select_lo = 1'h0;
  logic        font_bank_select = 1'h0;
  logic        register_select;
  logic        bus_dir_read;
  logic        bus_strobe;
  logic [7:0]  bus_data_in;
  logic [7:0]  bus_data_out;
  logic        bus_data_oe;
  logic [15:0] com_out;
  logic [39:0] seg_out;
  int          fails = 0;
  int          compares = 0;
  int          cycles = 0;
  logic [7:0]  r;
  logic [7:0]  glyph [8] = '{8'hEE, 8'h11, 8'h11, 8'h1F, 8'h11, 8'h11, 8'h11, 8'h00};

  always #10 sys_clk = ~sys_clk;

  // short home and blink counts keep the run small
  clhp_top #(.LONG_CYC(50), .BLINK_CYC(64)) dut (
    .sys_clk(sys_clk), .rst(rst), .iface_select_hi(iface_select_hi), .iface_select_lo(iface_select_lo),
    .font_bank_select(font_bank_select), .register_select(register_select), .bus_dir_read(bus_dir_read),
    .bus_strobe(bus_strobe), .bus_data_in(bus_data_in), .bus_data_out(bus_data_out),
    .bus_data_oe(bus_data_oe), .com_out(com_out), .seg_out(seg_out)
  );

  clhp_host host (
    .sys_clk(sys_clk), .bus_data_out(bus_data_out), .register_select(register_select),
    .bus_dir_read(bus_dir_read), .bus_strobe(bus_strobe), .bus_data_in(bus_data_in)
  );

  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  task automatic conclude;
    $display("Comparisons %0d, mismatches %0d", compares, fails);
    if (fails == 0 && compares > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : conclude

  task automatic check(input logic [7:0] seen, input logic [7:0] exp, input string what);
    compares++;
    if (seen !== exp)
    begin
      fails++;
      $display("Error at %0t: %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask : check

  task automatic cmd(input logic [7:0] d);
    host.wait_ready();
    host.xfer(1'h0, 1'h0, d, r);
  endtask : cmd

  task automatic wr(input logic [7:0] d);
    host.wait_ready();
    host.xfer(1'h1, 1'h0, d, r);
  endtask : wr

  task automatic status_is(input logic [7:0] exp, input string what);
    host.wait_ready();
    host.xfer(1'h0, 1'h1, 8'h00, r);
    check(r, exp, what);
  endtask : status_is

  task automatic read_is(input logic [7:0] exp, input string what);
    host.wait_ready();
    host.xfer(1'h1, 1'h1, 8'h00, r);
    check(r, exp, what);
  endtask : read_is

  task automatic wait_com(input logic [15:0] v);
    int n;
    n = 0;
    while (com_out !== v && n < 2000)
    begin
      @(posedge sys_clk);
      n++;
    end
  endtask : wait_com

  always @(posedge sys_clk)
  begin
    cycles++;
    if (cycles == LIMIT)
    begin
      fails++;
      conclude();
    end
  end

  // ---------------------------------------------------------------
  // sequence
  // ---------------------------------------------------------------
  initial
  begin
    repeat (10) @(posedge sys_clk);
    rst <= 1'h0;
    status_is(8'h00, "reset status");
    cmd(8'hA7);
    status_is(8'h27, "address load");
    wr(8'h41);
    status_is(8'h40, "line jump");
    wr(8'h42);
    cmd(8'hA7);
    read_is(8'h41, "first read");
    read_is(8'h42, "next read");
    status_is(8'h41, "read step");
    wr(8'h43);
    host.xfer(1'h0, 1'h1, 8'h00, r);
    check(r & 8'h80, 8'h80, "busy after write");
    host.xfer(1'h0, 1'h0, 8'h90, r);
    status_is(8'h42, "busy refusal");
    cmd(8'h04);
    cmd(8'h85);
    wr(8'h55);
    status_is(8'h04, "decrement");
    cmd(8'h06);
    cmd(8'h40);
    foreach (glyph[i]) wr(glyph[i]);
    status_is(8'h08, "font address");
    cmd(8'h40);
    foreach (glyph[i]) read_is(glyph[i] & 8'h1F, "font row");
    iface_select_lo <= 1'h1;
    host.xfer(1'h0, 1'h0, 8'h80, r);
    host.xfer(1'h0, 1'h1, 8'h00, r);
    check({7'h00, bus_data_oe}, 8'h00, "serial bus quiet");
    iface_select_lo <= 1'h0;
    status_is(8'h08, "serial ignored");
    cmd(8'h28);
    host.narrow = 1'h1;
    host.wait_ready();
    host.xfer(1'h0, 1'h1, 8'h00, r);
    check(r, 8'h00, "high nibble");
    host.xfer(1'h0, 1'h1, 8'h00, r);
    check(r, 8'h80, "low nibble");
    host.xfer(1'h0, 1'h0, 8'hA0, r);
    host.xfer(1'h0, 1'h0, 8'h50, r);
    host.wait_ready();
    host.xfer(1'h0, 1'h1, 8'h00, r);
    check(r, 8'h20, "nibble address high");
    host.xfer(1'h0, 1'h1, 8'h00, r);
    check(r, 8'h50, "nibble address low");
    host.xfer(1'h0, 1'h0, 8'h30, r);
    host.xfer(1'h0, 1'h0, 8'h80, r);
    host.narrow = 1'h0;
    status_is(8'h25, "width back");
    rst <= 1'h1;
    repeat (10) @(posedge sys_clk);
    rst <= 1'h0;
    status_is(8'h00, "second reset");
    cmd(8'h40);
    foreach (glyph[i]) wr(glyph[i]);
    cmd(8'h80);
    wr(8'h08);
    wr(8'h00);
    cmd(8'h0C);
    // a full frame after display on, so the latch holds fresh rows
    wait_com(16'h0002);
    wait_com(16'h0001);
    check({3'h0, seg_out[39:35]}, 8'h0E, "glyph via code 08");
    check({3'h0, seg_out[34:30]}, 8'h0E, "glyph via code 00");
    conclude();
  end
endmodule : clhp_bench
